// ===== verilog/ucfs_top.sv
// incoming utopia cell tally, parity statistics and unstructured port filter
// assumes 8-bit utopia data with soc on the first header byte; the utopia
// clock is sampled by mclk_in and its rising edges found in this domain
`timescale 1ns/1ps
`include "ucfs_consts.svh"
module ucfs_top
    import ucfs_pkg::*;
#(
    parameter int NPORTS = `UCFS_NPORTS
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // incoming utopia bus
    input wire logic uto_clk_in,
    input wire logic [7:0] incoming_cell_data_bus_in,
    input wire logic incoming_cell_parity_bit_in,
    input wire logic uto_soc_in,
    input wire logic uto_enb_n_in,
    input wire logic nni_mode_in,
    // microprocessor port
    input wire logic cpu_cs_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic [15:0] cpu_rdata_out,
    // summary and filter result
    output logic utopia_service_summary_out,
    output ucfs_verdict_t verdict_out
);
    // synchronisers: first stage read only by second
    logic [11:0] s1_ff, s2_ff;
    logic uclk_d_ff;
    logic nni_s1_ff, nni_s2_ff;
    logic [15:0] received_cell_tally_ff, nxt_received_cell_tally, par_cnt_ff, nxt_par_cnt;
    logic [1:0] status_ff, nxt_status, srv_en_ff, nxt_srv_en;
    logic [15:0] vci_ff [NPORTS], vpi_ff [NPORTS];
    logic [15:0] nxt_vci [NPORTS], nxt_vpi [NPORTS];
    ucfs_state_t st_ff, nxt_st;
    ucfs_hdr_t hdr_ff, nxt_hdr;
    ucfs_verdict_t verdict_ff, nxt_verdict;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [NPORTS-1:0] hit, keep;
    logic uedge, soc, enb_ok, par_err;
    logic [7:0] data;

    // two-stage capture of the whole utopia bus
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff <= 12'h000;
            s2_ff <= 12'h000;
            uclk_d_ff <= 1'b0;
            nni_s1_ff <= 1'b0;
            nni_s2_ff <= 1'b0;
        end else begin
            nni_s1_ff <= nni_mode_in; // mode pin is board-level, so it is retimed too
            nni_s2_ff <= nni_s1_ff;
            s1_ff <= {uto_clk_in, uto_soc_in, uto_enb_n_in, incoming_cell_parity_bit_in,
                incoming_cell_data_bus_in};
            s2_ff <= s1_ff;
            uclk_d_ff <= s2_ff[11];
        end
    end

    // rising utopia clock edge marks a bus sample
    always_comb begin
        uedge = s2_ff[11] & ~uclk_d_ff;
        soc = s2_ff[10];
        enb_ok = ~s2_ff[9];
        data = s2_ff[7:0];
        par_err = (^data) == s2_ff[8]; // odd parity expected
    end

    // address decode for a port register; returns the port or -1
    function automatic int port_of(input logic [15:0] a, input logic [15:0] base);
        int r;
        r = -1;
        for (int p = 0; p < NPORTS; p++) begin
            if (a == 16'(base + 16'(p) * `UCFS_PORT_STRIDE)) begin
                r = p;
            end
        end
        return r;
    endfunction

    // counters, flags and software writes
    always_comb begin
        int pv, pp;
        pv = port_of(cpu_addr_in, `UCFS_ADDR_VCI_BASE);
        pp = port_of(cpu_addr_in, `UCFS_ADDR_VPI_BASE);
        nxt_received_cell_tally = received_cell_tally_ff;
        nxt_par_cnt = par_cnt_ff;
        nxt_status = status_ff;
        nxt_srv_en = srv_en_ff;
        for (int p = 0; p < NPORTS; p++) begin
            nxt_vci[p] = vci_ff[p];
            nxt_vpi[p] = vpi_ff[p];
        end
        if (uedge && enb_ok && soc) begin
            nxt_received_cell_tally = received_cell_tally_ff + 16'h0001;
            if (received_cell_tally_ff == `UCFS_CNT_MAX) begin
                nxt_status[`UCFS_BIT_CELL_ROLL] = 1'b1;
            end
        end
        if (uedge && enb_ok && par_err) begin
            nxt_par_cnt = par_cnt_ff + 16'h0001;
            if (par_cnt_ff == `UCFS_CNT_MAX) begin
                nxt_status[`UCFS_BIT_PAR_ROLL] = 1'b1;
            end
        end
        if (cpu_cs_in && cpu_wr_in) begin
            if (cpu_addr_in == `UCFS_ADDR_SRV_EN) begin
                nxt_srv_en = cpu_wdata_in[1:0];
            end
            if (pv >= 0) begin
                nxt_vci[pv] = cpu_wdata_in;
            end
            if (pp >= 0) begin
                nxt_vpi[pp] = {3'b000, cpu_wdata_in[`UCFS_OAM_BIT:0]};
            end
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        int pv, pp;
        pv = port_of(cpu_addr_in, `UCFS_ADDR_VCI_BASE);
        pp = port_of(cpu_addr_in, `UCFS_ADDR_VPI_BASE);
        nxt_rdata = rdata_ff;
        if (cpu_cs_in && cpu_rd_in) begin
            nxt_rdata = 16'h0000;
            case (cpu_addr_in)
                `UCFS_ADDR_STATUS: nxt_rdata = {14'h0000, status_ff};
                `UCFS_ADDR_SRV_EN: nxt_rdata = {14'h0000, srv_en_ff};
                `UCFS_ADDR_CELLCNT: nxt_rdata = received_cell_tally_ff;
                `UCFS_ADDR_PARCNT: nxt_rdata = par_cnt_ff;
                default: begin
                    if (pv >= 0) begin
                        nxt_rdata = vci_ff[pv];
                    end else if (pp >= 0) begin
                        nxt_rdata = vpi_ff[pp];
                    end
                end
            endcase
        end
    end

    // header capture: vpi/vci/pti from bytes 0..3 of an 8-bit cell
    always_comb begin
        nxt_st = st_ff;
        nxt_hdr = hdr_ff;
        nxt_verdict = verdict_ff;
        nxt_verdict.valid = 1'b0;
        if (uedge && enb_ok) begin
            case (st_ff)
                UCFS_IDLE, UCFS_DONE: begin
                    if (soc) begin
                        nxt_hdr.vpi = {data, 4'h0};
                        nxt_st = UCFS_W1;
                    end else begin
                        nxt_st = UCFS_IDLE;
                    end
                end
                UCFS_W1: begin
                    nxt_hdr.vpi = {hdr_ff.vpi[11:4], data[7:4]};
                    nxt_hdr.vci = {data[3:0], 12'h000};
                    nxt_st = UCFS_W2;
                end
                UCFS_W2: begin
                    nxt_hdr.vci = {hdr_ff.vci[15:12], data, 4'h0};
                    nxt_st = UCFS_W3;
                end
                UCFS_W3: begin
                    nxt_hdr.vci = {hdr_ff.vci[15:4], data[7:4]};
                    nxt_hdr.pti = data[3:1];
                    nxt_st = UCFS_DONE;
                end
                default: nxt_st = UCFS_IDLE;
            endcase
        end
        // last header byte taken: the verdict fires one cycle later
        if (st_ff == UCFS_W3 && nxt_st == UCFS_DONE) begin
            nxt_verdict.valid = 1'b1;
        end
    end

    // verdict is taken from the header in the cycle after capture completes
    logic fire_ff;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            fire_ff <= 1'b0;
        end else begin
            fire_ff <= nxt_verdict.valid;
        end
    end

    // uni headers carry gfc in the top nibble; clear it for the compare layout
    ucfs_hdr_t cmp_hdr;
    always_comb begin
        cmp_hdr = hdr_ff;
        if (!nni_s2_ff) begin
            cmp_hdr.vpi = {4'h0, hdr_ff.vpi[7:0]};
        end
    end

    generate
        for (genvar g = 0; g < NPORTS; g++) begin : g_match
            ucfs_port_match u_match (
                .prog_vci_in(vci_ff[g]),
                .prog_vpi_oam_in(vpi_ff[g]),
                .hdr_in(cmp_hdr),
                .nni_mode_in(nni_s2_ff),
                .hit_out(hit[g]),
                .keep_out(keep[g])
            );
        end
    endgenerate

    // lowest matching port wins
    ucfs_verdict_t res;
    always_comb begin
        res = '0;
        res.valid = fire_ff;
        for (int p = NPORTS - 1; p >= 0; p--) begin
            if (hit[p]) begin
                res.hit = 1'b1;
                res.port = 3'(p);
                res.keep = keep[p];
            end
        end
    end

    // register every state group other than the synchronisers and fire_ff
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            received_cell_tally_ff <= 16'h0000;
            par_cnt_ff <= 16'h0000;
            status_ff <= 2'b00;
            srv_en_ff <= 2'b00;
            st_ff <= UCFS_IDLE;
            hdr_ff <= '0;
            verdict_ff <= '0;
            rdata_ff <= 16'h0000;
            for (int p = 0; p < NPORTS; p++) begin
                vci_ff[p] <= 16'h0000;
                vpi_ff[p] <= 16'h0000;
            end
        end else begin
            received_cell_tally_ff <= nxt_received_cell_tally;
            par_cnt_ff <= nxt_par_cnt;
            status_ff <= nxt_status;
            srv_en_ff <= nxt_srv_en;
            st_ff <= nxt_st;
            hdr_ff <= nxt_hdr;
            verdict_ff <= fire_ff ? res : '0;
            rdata_ff <= nxt_rdata;
            for (int p = 0; p < NPORTS; p++) begin
                vci_ff[p] <= nxt_vci[p];
                vpi_ff[p] <= nxt_vpi[p];
            end
        end
    end

    // summary is a level of the gated latched flags
    always_comb begin
        utopia_service_summary_out = (srv_en_ff[`UCFS_BIT_CELL_ROLL]
            & status_ff[`UCFS_BIT_CELL_ROLL])
            | (srv_en_ff[`UCFS_BIT_PAR_ROLL] & status_ff[`UCFS_BIT_PAR_ROLL]);
        cpu_rdata_out = rdata_ff;
        verdict_out = verdict_ff;
    end
endmodule

// ===== common/ucfs_consts.svh
// constants for the incoming utopia cell filter and statistics block
// assumes a 16-bit microprocessor port with byte addresses
`ifndef UCFS_CONSTS_SVH
`define UCFS_CONSTS_SVH
`define UCFS_ADDR_STATUS 16'h4012
`define UCFS_ADDR_SRV_EN 16'h4014
`define UCFS_ADDR_CELLCNT 16'h4016
`define UCFS_ADDR_PARCNT 16'h400e
`define UCFS_ADDR_VCI_BASE 16'h4200
`define UCFS_ADDR_VPI_BASE 16'h4202
`define UCFS_PORT_STRIDE 16'h0004
`define UCFS_NPORTS 8
`define UCFS_BIT_CELL_ROLL 0
`define UCFS_BIT_PAR_ROLL 1
`define UCFS_VPI_MSB 11
`define UCFS_OAM_BIT 12
`define UCFS_UNI_VPI_MASK 12'h0ff
`define UCFS_NNI_VPI_MASK 12'hfff
`define UCFS_CNT_MAX 16'hffff
`define UCFS_PTI_OAM_BIT 2
`define UCFS_VCI_OAM_SEG 16'h0003
`define UCFS_VCI_OAM_E2E 16'h0004
`endif

// ===== common/ucfs_pkg.sv
// types shared by the cell filter block
// assumes the constants header is on the include path
package ucfs_pkg;
    // one incoming cell header, as taken from the utopia bus
    typedef struct packed {
        logic [11:0] vpi;
        logic [15:0] vci;
        logic [2:0] pti;
    } ucfs_hdr_t;
    // outcome of filtering one cell
    typedef struct packed {
        logic valid;
        logic keep;
        logic [2:0] port;
        logic hit;
    } ucfs_verdict_t;
    // header capture states, one-hot
    typedef enum logic [4:0] {
        UCFS_IDLE = 5'b00001,
        UCFS_W1 = 5'b00010,
        UCFS_W2 = 5'b00100,
        UCFS_W3 = 5'b01000,
        UCFS_DONE = 5'b10000
    } ucfs_state_t;
endpackage

// ===== verilog/ucfs_port_match.sv
// per-port vpi/vci comparison for one tdm port
`timescale 1ns/1ps
`include "ucfs_consts.svh"
module ucfs_port_match
    import ucfs_pkg::*;
(
    // programmed connection
    input wire logic [15:0] prog_vci_in,
    input wire logic [15:0] prog_vpi_oam_in,
    // incoming header and mode
    input wire ucfs_hdr_t hdr_in,
    input wire logic nni_mode_in,
    // result
    output logic hit_out,
    output logic keep_out
);
    logic [11:0] vpi_mask;
    logic is_oam;
    // uni leaves the gfc nibble out of the compare
    always_comb begin
        vpi_mask = nni_mode_in ? `UCFS_NNI_VPI_MASK : `UCFS_UNI_VPI_MASK;
        is_oam = hdr_in.pti[`UCFS_PTI_OAM_BIT] | (hdr_in.vci == `UCFS_VCI_OAM_SEG)
            | (hdr_in.vci == `UCFS_VCI_OAM_E2E);
        hit_out = (hdr_in.vci == prog_vci_in)
            && (((hdr_in.vpi ^ prog_vpi_oam_in[`UCFS_VPI_MSB:0]) & vpi_mask) == 12'h000);
        keep_out = hit_out && (!is_oam || prog_vpi_oam_in[`UCFS_OAM_BIT]);
    end
endmodule

// ===== verif/ucfs_props.sv
// port checker for the incoming cell filter and statistics top
// bound onto ucfs_top from the testbench file; sees only top ports
`timescale 1ns/1ps
module ucfs_props
    import ucfs_pkg::*;
#(
    parameter int NPORTS = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // microprocessor port
    input wire logic cpu_cs_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    input wire logic [15:0] cpu_rdata_out,
    // results
    input wire logic utopia_service_summary_out,
    input wire ucfs_verdict_t verdict_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic rd, wr;
    logic [15:0] en_ff, vpi_ff;
    // plain strobes; a cycle with both set is left unjudged
    assign rd = cpu_cs_in && cpu_rd_in && !cpu_wr_in;
    assign wr = cpu_cs_in && cpu_wr_in && !cpu_rd_in;
    // shadow of the enable and port 0 vpi registers, both reset to zero
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            en_ff <= 16'h0000;
            vpi_ff <= 16'h0000;
        end else if (wr && cpu_addr_in == 16'h4014) begin
            en_ff <= cpu_wdata_in;
        end else if (wr && cpu_addr_in == 16'h4202) begin
            vpi_ff <= cpu_wdata_in;
        end
    end
    a_enable_rdback: assert property (
        rd && cpu_addr_in == 16'h4014 |=> cpu_rdata_out == (en_ff & 16'h0003))
        else $error("service enable readback wrong");
    a_vpi_rdback: assert property (
        rd && cpu_addr_in == 16'h4202 |=> cpu_rdata_out == (vpi_ff & 16'h1fff))
        else $error("port vpi readback wrong");
    a_vpi_upper_zero: assert property (
        rd && cpu_addr_in[15:5] == 11'h210 && cpu_addr_in[1] |=> cpu_rdata_out[15:13] == 3'h0)
        else $error("vpi upper bits not zero");
    a_status_upper: assert property (
        rd && cpu_addr_in == 16'h4012 |=> cpu_rdata_out[15:2] == 14'h0000)
        else $error("status upper bits not zero");
    a_summary_off: assert property (
        en_ff[1:0] == 2'b00 |-> !utopia_service_summary_out)
        else $error("summary set with enables off");
    a_keep_hit: assert property (
        verdict_out.valid && verdict_out.keep |-> verdict_out.hit)
        else $error("cell kept without a match");
    a_verdict_pulse: assert property (
        $rose(verdict_out.valid) |=> !verdict_out.valid ##1 !verdict_out.valid)
        else $error("verdict longer than one cycle");
    a_reset_clear: assert property (
        $fell(rst_in) |-> cpu_rdata_out == 16'h0000 && !verdict_out.valid)
        else $error("outputs not clear after reset");
endmodule

// ===== verif/ucfs_phy_model.sv
// utopia transmitter standing at the incoming cell port
// the bench calls send_cell; the link clock only runs inside a cell
`timescale 1ns/1ps
module ucfs_phy_model #(
    parameter int CELL_BYTES = 53
) (
    // utopia pins toward the block
    output logic uto_clk_out,
    output logic [7:0] data_out,
    output logic parity_out,
    output logic soc_out,
    output logic enb_n_out
);
    // idle: clock parked low, bus disabled
    initial begin
        uto_clk_out = 1'b0;
        data_out = 8'h5a;
        parity_out = 1'b0;
        soc_out = 1'b0;
        enb_n_out = 1'b1;
    end
    // bytes launched on the falling link edge; the first nbad carry bad parity
    task automatic send_cell(input logic [31:0] hdr, input int nbad);
        #7;
        for (int i = 0; i < CELL_BYTES; i++) begin
            #80 uto_clk_out = 1'b0;
            data_out = (i < 4) ? hdr[31 - 8 * i -: 8] : 8'($urandom);
            soc_out = (i == 0);
            enb_n_out = 1'b0;
            parity_out = ~^data_out ^ (i < nbad);
            #80 uto_clk_out = 1'b1;
        end
        #80 uto_clk_out = 1'b0;
        // released bus shows the inverse so a stale byte never looks valid
        data_out = ~data_out;
        parity_out = ~parity_out;
        soc_out = 1'b0;
        enb_n_out = 1'b1;
    endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the incoming cell filter and statistics block
// drives the cpu port itself and the utopia port through the phy model
`timescale 1ns/1ps
`include "ucfs_consts.svh"
module testbench
    import ucfs_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, nni = 1'b0, cs = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, got;
    logic uclk, upar, usoc, uenb_n, summary;
    logic [7:0] udata;
    ucfs_verdict_t verdict, vq[$];
    logic [15:0] pvci [8], pvpi [8];
    int n_mismatch = 0, total_checks = 0, nbad = 0;
    ucfs_phy_model u_phy (.uto_clk_out(uclk), .data_out(udata), .parity_out(upar),
        .soc_out(usoc), .enb_n_out(uenb_n));
    ucfs_top #(.NPORTS(8)) u_dut (.mclk_in(mclk), .rst_in(rst), .uto_clk_in(uclk),
        .incoming_cell_data_bus_in(udata), .incoming_cell_parity_bit_in(upar),
        .uto_soc_in(usoc), .uto_enb_n_in(uenb_n), .nni_mode_in(nni), .cpu_cs_in(cs),
        .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
        .cpu_rdata_out(rdata), .utopia_service_summary_out(summary), .verdict_out(verdict));
    // 50 mhz master clock
    always #10 mclk = ~mclk;
    // every verdict pulse is queued for the cell loop
    always @(negedge mclk) if (verdict.valid === 1'b1) vq.push_back(verdict);
    task automatic report_and_stop();
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check16(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one cpu access; read data is taken once it has settled
    task automatic cpu(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        #1 {cs, wr, rd, addr, wdata} = {1'b1, w, ~w, a, d};
        @(posedge mclk);
        #1 {cs, wr, rd} = 3'b000;
        @(posedge mclk);
        #1 got = rdata;
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [15:0] e);
        cpu(1'b0, a, 16'h0000);
        check16(got, e);
    endtask
    // port is only meaningful on a hit
    task automatic check_verdict(input ucfs_verdict_t e);
        ucfs_verdict_t g;
        g = (vq.size() > 0) ? vq.pop_front() : 'x;
        if (!e.hit) g.port = e.port;
        check16(16'(g), 16'(e));
    endtask
    // lowest matching port wins; oam cells kept only with keep select set
    function automatic ucfs_verdict_t exp_verdict(input logic [31:0] h, input logic nm);
        ucfs_verdict_t v;
        logic [11:0] m;
        logic oam;
        v = '0;
        v.valid = 1'b1;
        m = nm ? 12'hfff : 12'h0ff;
        oam = h[3] || h[19:4] == 16'h3 || h[19:4] == 16'h4;
        for (int p = 7; p >= 0; p--)
            if (h[19:4] == pvci[p] && ((h[31:20] ^ pvpi[p][11:0]) & m) == 12'h000) begin
                v.hit = 1'b1;
                v.port = 3'(p);
            end
        v.keep = v.hit && (!oam || pvpi[v.port][12]);
        return v;
    endfunction
    // hang guard, far beyond the 40 cells of the run
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h0a0023fe));
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        rd_check(`UCFS_ADDR_CELLCNT, 16'h0000);
        rd_check(`UCFS_ADDR_PARCNT, 16'h0000);
        rd_check(`UCFS_ADDR_STATUS, 16'h0000);
        rd_check(16'h4000, 16'h0000);
        cpu(1'b1, `UCFS_ADDR_CELLCNT, 16'h1234);
        rd_check(`UCFS_ADDR_CELLCNT, 16'h0000);
        cpu(1'b1, `UCFS_ADDR_SRV_EN, 16'hffff);
        rd_check(`UCFS_ADDR_SRV_EN, 16'h0003);
        check16({15'h0, summary}, 16'h0000);
        // program every port; vci kept distinct and clear of oam codes
        for (int p = 0; p < 8; p++) begin
            rd_check(`UCFS_ADDR_VPI_BASE + 16'(4 * p), 16'h0000);
            pvci[p] = {12'($urandom), 1'b1, 3'(p)};
            pvpi[p] = {3'b000, p[0], 12'($urandom)};
            cpu(1'b1, `UCFS_ADDR_VCI_BASE + 16'(4 * p), pvci[p]);
            cpu(1'b1, `UCFS_ADDR_VPI_BASE + 16'(4 * p), pvpi[p] | 16'he000);
            rd_check(`UCFS_ADDR_VCI_BASE + 16'(4 * p), pvci[p]);
            rd_check(`UCFS_ADDR_VPI_BASE + 16'(4 * p), pvpi[p]);
        end
        // first four: gfc-only difference on oam cells in both modes, then random
        for (int n = 0; n < 40; n++) begin
            logic [31:0] h;
            int p, k, b;
            p = $urandom_range(7);
            k = $urandom_range(3);
            b = $urandom_range(2);
            nni = 1'($urandom);
            h = {pvpi[p][11:0], pvci[p], 4'($urandom)};
            if (k == 1) h[31:28] = 4'($urandom);
            if (k == 2) h[20 + $urandom_range(11)] ^= 1'b1;
            if (k == 3) h[19:4] = 16'($urandom);
            if (n < 4) begin
                h = {pvpi[n % 2][11:0] ^ 12'ha00, pvci[n % 2], 4'hb};
                nni = n[1];
            end
            vq.delete();
            u_phy.send_cell(h, b);
            repeat (8) @(posedge mclk);
            #1;
            check_verdict(exp_verdict(h, nni));
            nbad += b;
        end
        rd_check(`UCFS_ADDR_CELLCNT, 16'h0028);
        rd_check(`UCFS_ADDR_PARCNT, 16'(nbad));
        // mid-run reset must clear tallies and enables
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        rd_check(`UCFS_ADDR_CELLCNT, 16'h0000);
        rd_check(`UCFS_ADDR_PARCNT, 16'h0000);
        rd_check(`UCFS_ADDR_SRV_EN, 16'h0000);
        report_and_stop();
    end
endmodule
bind ucfs_top ucfs_props #(.NPORTS(NPORTS)) u_props (.mclk_in(mclk_in), .rst_in(rst_in),
    .cpu_cs_in(cpu_cs_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
    .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
    .utopia_service_summary_out(utopia_service_summary_out), .verdict_out(verdict_out));
